// [src/smtc_top.v]
/*
 * Special-mode privilege and factory-test control: mode capture at reset,
 * vector relocation, privilege flag, test-function register, serial-rate
 * test bits and the gating of watchdog and clock-monitor resets.
 * Assumes a classic Wishbone master, one clock (the E clock) and that the
 * watchdog, clock monitor, timer and serial blocks live outside.
 */
// Implementation choice: the Wishbone interface to the registers.
`include "smtc_regs.vh"

// How it works
// - Mode pin low at reset: special, vectors BFC0
// - Bootstrap mode maps boot ROM BF40-BFFF
// - Special test: reset vector always external
// - Special flag set at reset; gates test functions
// - Boot/expansion bits free; flag, visibility clear-only
// - Configuration programming only while flag set
// - Time protection lifted in special modes
// - Test register reads zero, ignores writes normally
// - Test register layout; reset disable resets 1
// - Test bits writable only while flag set
// - Illegal-opcode test: consecutive cycles, address counts down
// - Condition-code output drives port A 7-3
// - Condition-code output removes internal ROM
// - Timer bypass splits timer, E clock direct
// - Reset disable blocks resets; forced 0 normally
// - Forced clock-monitor fail resets if enabled
// - Forced watchdog timeout resets if enabled
// - Override maps ROM, EEPROM, enables watchdog
// - Baud test bits special-only, cleared, read 0
// - Baud chain clear write resets counter chain
// - Baud clock test drives xor onto port D
module smtc_top #(
    parameter PROT_CYCLES = `SMTC_PROT_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    input wire wb_sel_i,
    output reg [7:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // Mode pins
    input wire mode_select_b_pin_i,
    input wire mode_select_a_pin_i,
    // Configuration and neighbour status
    input wire rom_enable_config_i,
    input wire eeprom_enable_config_i,
    input wire watchdog_disable_config_i,
    input wire clock_monitor_enable_i,
    input wire watchdog_timeout_i,
    input wire clock_monitor_fail_i,
    input wire [4:0] ccr_flags_i,
    input wire [7:0] port_a_normal_i,
    input wire illegal_opcode_seen_i,
    input wire rx_clock_16x_i,
    input wire tx_clock_i,
    input wire port_d_line_one_normal_i,
    input wire [15:0] addr_bus_i,
    // Mode outputs
    output reg special_mode_flag_o,
    output reg boot_rom_enable_o,
    output reg expansion_bus_mode_bit_o,
    output reg internal_read_visibility_o,
    output wire [15:0] vector_base_o,
    output wire boot_rom_map_o,
    output wire reset_vector_external_o,
    output wire config_write_enable_o,
    output wire time_protect_lift_o,
    output wire prot_window_open_o,
    // Test function outputs
    output wire illegal_opcode_test_o,
    output wire instruction_start_pin_o,
    output reg [15:0] test_addr_o,
    output reg test_addr_drive_o,
    output wire [7:0] port_a_o,
    output wire internal_rom_map_o,
    output wire eeprom_map_o,
    output wire watchdog_enable_o,
    output wire timer_chain_bypass_o,
    output wire system_reset_req_o,
    output reg forced_cm_reset_o,
    output reg forced_wd_reset_o,
    output reg baud_chain_clear_o,
    output wire port_d_line_one_o
);
    reg [7:0] tfr_q;
    reg baud_ckt_q;
    reg [6:0] prot_cnt_q;
    reg capt_q;
    reg special_test_q;
    reg [15:0] addr_cnt_q;
    wire mode_select_b_pin_s;
    wire moda_s;
    wire acc;
    wire wr;
    wire hit_tfr;
    wire hit_baud;
    wire hit_mode;
    wire hit_prot;
    wire hit_stat;
    wire cco;
    wire ovr;
    wire reset_disable;

    // =================================================================
    // Pin synchronisers
    smtc_sync2 u_sync_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mode_select_b_pin_i),
        .q_o(mode_select_b_pin_s)
    );

    smtc_sync2 u_sync_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mode_select_a_pin_i),
        .q_o(moda_s)
    );

    // =================================================================
    // Bus decode; one-cycle ack, unmapped addresses answer with err
    function match;
        input [15:0] a;
        input [15:0] r;
        begin
            match = (a == r);
        end
    endfunction

    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit_tfr = match(wb_adr_i, `SMTC_ADDR_TFR);
    assign hit_baud = match(wb_adr_i, `SMTC_ADDR_BAUD);
    assign hit_mode = match(wb_adr_i, `SMTC_ADDR_MODE);
    assign hit_prot = match(wb_adr_i, `SMTC_ADDR_PROT);
    assign hit_stat = match(wb_adr_i, `SMTC_ADDR_STAT);
    assign wr = acc & wb_we_i & wb_sel_i;

    assign cco = tfr_q[`SMTC_TFR_CCO];
    assign ovr = tfr_q[`SMTC_TFR_OVR];
    assign reset_disable = tfr_q[`SMTC_TFR_RESET_DISABLE];

    // =================================================================
    // Mode capture: the pin is sampled in the first cycle after reset
    // release, once the synchroniser holds the real level
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            capt_q <= 1'b0;
            special_mode_flag_o <= 1'b0;
            boot_rom_enable_o <= 1'b0;
            expansion_bus_mode_bit_o <= 1'b0;
            internal_read_visibility_o <= 1'b0;
            special_test_q <= 1'b0;
        end
        else if (!capt_q)
        begin
            capt_q <= 1'b1;
            special_mode_flag_o <= ~mode_select_b_pin_s;
            boot_rom_enable_o <= ~mode_select_b_pin_s & ~moda_s;
            expansion_bus_mode_bit_o <= moda_s;
            internal_read_visibility_o <= ~mode_select_b_pin_s;
            special_test_q <= ~mode_select_b_pin_s & moda_s;
        end
        else if (wr && hit_mode && special_mode_flag_o)
        begin
            // Free bits follow the write; flag and visibility only clear
            boot_rom_enable_o <= wb_dat_i[`SMTC_MODE_BOOT];
            expansion_bus_mode_bit_o <= wb_dat_i[`SMTC_MODE_EXPB];
            special_mode_flag_o <= wb_dat_i[`SMTC_MODE_SPECIAL_MODE_FLAG];
            internal_read_visibility_o <= internal_read_visibility_o
                & wb_dat_i[`SMTC_MODE_IRV];
        end
    end

    // Vector placement and boot ROM map
    assign vector_base_o = special_mode_flag_o ? `SMTC_VEC_SPECIAL
        : `SMTC_VEC_NORMAL;
    assign boot_rom_map_o = special_mode_flag_o & boot_rom_enable_o;
    assign reset_vector_external_o = special_test_q & special_mode_flag_o;
    assign config_write_enable_o = special_mode_flag_o;

    // =================================================================
    // Protection window counter for time-protected bits elsewhere
    always @(posedge clk_i)
    begin
        if (rst_i)
            prot_cnt_q <= 7'h00;
        else if (prot_cnt_q != PROT_CYCLES[6:0])
            prot_cnt_q <= prot_cnt_q + 7'h01;
    end

    assign prot_window_open_o = (prot_cnt_q != PROT_CYCLES[6:0]) | special_mode_flag_o;
    assign time_protect_lift_o = special_mode_flag_o;

    // =================================================================
    // Test-function register; cleared whenever the flag drops
    always @(posedge clk_i)
    begin
        if (rst_i)
            tfr_q <= `SMTC_TFR_RESET;
        else if (!capt_q)
            tfr_q <= {4'h0, ~mode_select_b_pin_s, 3'h0};
        else if (!special_mode_flag_o)
            tfr_q <= 8'h00;
        else if (wr && hit_tfr)
            tfr_q <= wb_dat_i & `SMTC_TFR_WMASK & 8'hf9;
    end

    // Forced resets fire on the write only, never held
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            forced_cm_reset_o <= 1'b0;
            forced_wd_reset_o <= 1'b0;
        end
        else
        begin
            forced_cm_reset_o <= wr & hit_tfr & special_mode_flag_o
                & wb_dat_i[`SMTC_TFR_FCM] & clock_monitor_enable_i
                & ~reset_disable;
            forced_wd_reset_o <= wr & hit_tfr & special_mode_flag_o
                & wb_dat_i[`SMTC_TFR_FWD]
                & (~watchdog_disable_config_i | ovr) & ~reset_disable;
        end
    end

    // Reset disable masks every watchdog and clock-monitor source
    assign system_reset_req_o = ~reset_disable & (watchdog_timeout_i | clock_monitor_fail_i
        | forced_cm_reset_o | forced_wd_reset_o);

    // =================================================================
    // Configuration and memory map
    assign watchdog_enable_o = ovr | ~watchdog_disable_config_i;
    assign eeprom_map_o = ovr | eeprom_enable_config_i;
    assign internal_rom_map_o = ~cco & (ovr | rom_enable_config_i);

    // Port A: condition codes on bits 7-3 when enabled
    assign port_a_o = cco ? {ccr_flags_i, port_a_normal_i[2:0]}
        : port_a_normal_i;
    assign timer_chain_bypass_o = tfr_q[`SMTC_TFR_BYP];

    // =================================================================
    // Illegal-opcode test: after the first one the address counts down
    assign illegal_opcode_test_o = tfr_q[`SMTC_TFR_ILOP];
    assign instruction_start_pin_o = illegal_opcode_test_o & illegal_opcode_seen_i;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_cnt_q <= 16'h0000;
            test_addr_o <= 16'h0000;
            test_addr_drive_o <= 1'b0;
        end
        else if (!illegal_opcode_test_o)
        begin
            test_addr_drive_o <= 1'b0;
            test_addr_o <= 16'h0000;
        end
        else if (!test_addr_drive_o)
        begin
            if (illegal_opcode_seen_i)
            begin
                test_addr_drive_o <= 1'b1;
                addr_cnt_q <= addr_bus_i - 16'h0001;
                test_addr_o <= addr_bus_i - 16'h0001;
            end
        end
        else
        begin
            addr_cnt_q <= addr_cnt_q - 16'h0001;
            test_addr_o <= addr_cnt_q - 16'h0001;
        end
    end

    // =================================================================
    // Serial-rate test bits; write-only, clear on leaving special mode
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            baud_ckt_q <= 1'b0;
            baud_chain_clear_o <= 1'b0;
        end
        else
        begin
            baud_chain_clear_o <= wr & hit_baud & special_mode_flag_o
                & wb_dat_i[`SMTC_BAUD_CLR];
            if (!special_mode_flag_o)
                baud_ckt_q <= 1'b0;
            else if (wr && hit_baud)
                baud_ckt_q <= wb_dat_i[`SMTC_BAUD_CKT];
        end
    end

    // Xor of both serial clocks goes out for factory monitoring
    assign port_d_line_one_o = baud_ckt_q ? (rx_clock_16x_i ^ tx_clock_i)
        : port_d_line_one_normal_i;

    // =================================================================
    // Bus answer: read data registered alongside the ack
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else
        begin
            wb_ack_o <= acc & (hit_tfr | hit_baud | hit_mode | hit_prot | hit_stat);
            wb_err_o <= acc & ~(hit_tfr | hit_baud | hit_mode | hit_prot | hit_stat);
            wb_dat_o <= 8'h00;
            if (acc && !wb_we_i)
            begin
                if (hit_tfr)
                    wb_dat_o <= special_mode_flag_o ? (tfr_q & 8'hbf) : 8'h00;
                else if (hit_mode)
                    wb_dat_o <= {boot_rom_enable_o, special_mode_flag_o,
                        expansion_bus_mode_bit_o, internal_read_visibility_o, 4'h0};
                else if (hit_stat)
                    wb_dat_o <= {5'h00, special_test_q, prot_window_open_o,
                        system_reset_req_o};
                // Serial-rate test bits have no read path and read zero
            end
        end
    end
endmodule // smtc_top

// [src/smtc_regs.vh]
/*
 * Register offsets, field positions, reset values and timing counts for the
 * special-mode and factory-test control block.
 * Assumes a classic Wishbone slave with 8-bit data in the low byte lanes.
 */
`ifndef SMTC_REGS_VH
`define SMTC_REGS_VH

// =====================================================================
// Register byte addresses (16-bit bus space)
`define SMTC_ADDR_BAUD 16'h102b
`define SMTC_ADDR_TFR 16'h103e
`define SMTC_ADDR_MODE 16'h103c
`define SMTC_ADDR_PROT 16'h1039
`define SMTC_ADDR_STAT 16'h1040

// =====================================================================
// Test-function register fields
`define SMTC_TFR_ILOP 7
`define SMTC_TFR_CCO 5
`define SMTC_TFR_BYP 4
`define SMTC_TFR_RESET_DISABLE 3
`define SMTC_TFR_FCM 2
`define SMTC_TFR_FWD 1
`define SMTC_TFR_OVR 0
`define SMTC_TFR_WMASK 8'hbf
`define SMTC_TFR_RESET 8'h00

// Serial rate register test fields
`define SMTC_BAUD_CLR 7
`define SMTC_BAUD_CKT 6
`define SMTC_BAUD_TMASK 8'hc0

// Mode register fields
`define SMTC_MODE_BOOT 7
`define SMTC_MODE_SPECIAL_MODE_FLAG 6
`define SMTC_MODE_EXPB 5
`define SMTC_MODE_IRV 4

// =====================================================================
// Vector and memory ranges
`define SMTC_VEC_SPECIAL 16'hbfc0
`define SMTC_VEC_NORMAL 16'hffc0
`define SMTC_BOOT_LO 16'hbf40
`define SMTC_BOOT_HI 16'hbfff
`define SMTC_ROM_LO 16'he000

// Protection window after reset, in E-clock cycles
`define SMTC_PROT_CYCLES 64

`endif

// [src/smtc_sync2.v]
/*
 * Two-flip-flop synchroniser for one asynchronous level.
 * Assumes clk_i is the block clock and rst_i a synchronous reset.
 */
module smtc_sync2 (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Level
    input wire d_i,
    output wire q_o
);
    reg meta_q;
    reg sync_q;

    // =================================================================
    // Only the second stage is ever read. The stages keep sampling through
    // reset, so the pin level has settled when reset lifts and the mode
    // capture reads it; clearing them here would always report special mode.
    always @(posedge clk_i)
    begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end

    assign q_o = sync_q;
endmodule // smtc_sync2

// [tb/smtc_top_assertions.sv]
/*
 * Port checker for the special-mode and factory-test control block.
 * Assumes it is bound to smtc_top; one clock, synchronous active-high reset.
 */
module smtc_checker #(
    parameter PROT_CYCLES = 64
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Watched outputs
    input wire logic special_mode_flag_o,
    input wire logic [15:0] vector_base_o,
    input wire logic illegal_opcode_test_o,
    input wire logic timer_chain_bypass_o,
    input wire logic forced_cm_reset_o,
    input wire logic forced_wd_reset_o,
    input wire logic baud_chain_clear_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // =====================================================================
    // Qualified writes that may cause a pulse
    wire req = wb_cyc_i && wb_stb_i;
    wire wd_w = req && wb_we_i && wb_adr_i == 16'h103e && wb_dat_i[1] && special_mode_flag_o;
    wire bc_w = req && wb_we_i && wb_adr_i == 16'h102b && wb_dat_i[7] && special_mode_flag_o;

    property p_ack_latency;
        req && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
    endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("bus answer late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_vector;
        special_mode_flag_o |-> vector_base_o == 16'hbfc0;
    endproperty
    a_vector: assert property (p_vector) else $error("special vector base wrong");
    // Software may clear the flag but only a reset may raise it
    property p_flag_rise;
        $rose(special_mode_flag_o) |-> $past(rst_i) || $past(rst_i, 2) || $past(rst_i, 3);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set by software");
    property p_normal_zero;
        !special_mode_flag_o && $past(!special_mode_flag_o)
            |-> !illegal_opcode_test_o && !timer_chain_bypass_o;
    endproperty
    a_normal_zero: assert property (p_normal_zero) else $error("test bit live in normal");
    property p_cm_pulse;
        forced_cm_reset_o |=> !forced_cm_reset_o;
    endproperty
    a_cm_pulse: assert property (p_cm_pulse) else $error("forced reset held");
    property p_wd_cause;
        forced_wd_reset_o |-> $past(wd_w) || $past(wd_w, 2);
    endproperty
    a_wd_cause: assert property (p_wd_cause) else $error("watchdog pulse uncaused");
    property p_bc_cause;
        baud_chain_clear_o |-> $past(bc_w) || $past(bc_w, 2);
    endproperty
    a_bc_cause: assert property (p_bc_cause) else $error("chain clear uncaused");

    // Main scenarios reached
    c_cm: cover property (forced_cm_reset_o);
    c_wd: cover property (forced_wd_reset_o);
    c_bc: cover property (baud_chain_clear_o);
endmodule // smtc_checker

bind smtc_top smtc_checker #(.PROT_CYCLES(PROT_CYCLES)) smtc_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .special_mode_flag_o(special_mode_flag_o),
    .vector_base_o(vector_base_o), .illegal_opcode_test_o(illegal_opcode_test_o),
    .timer_chain_bypass_o(timer_chain_bypass_o), .forced_cm_reset_o(forced_cm_reset_o),
    .forced_wd_reset_o(forced_wd_reset_o), .baud_chain_clear_o(baud_chain_clear_o)
);

// [tb/smtc_top_tb.sv]
/*
 * Self-checking bench: mode capture, test register, forced resets, serial test bits.
 * Assumes the checker binds itself; 250 MHz clock.
 */
module smtc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_sel_i = 0, er;
    logic [15:0] wb_adr_i = 16'h0000, addr_bus_i = 16'h0000, vector_base_o;
    logic [7:0] wb_dat_i = 8'h00, port_a_normal_i = 8'ha5, wb_dat_o, port_a_o, rd;
    logic [4:0] ccr_flags_i = 5'h15;
    logic mode_select_b_pin_i = 0, mode_select_a_pin_i = 0, rom_enable_config_i = 1;
    logic eeprom_enable_config_i = 1, watchdog_disable_config_i = 0, clock_monitor_enable_i = 1;
    logic watchdog_timeout_i = 0, clock_monitor_fail_i = 0, illegal_opcode_seen_i = 0;
    logic rx_clock_16x_i = 0, tx_clock_i = 0, port_d_line_one_normal_i = 0, wb_ack_o, wb_err_o;
    logic special_mode_flag_o, boot_rom_map_o, reset_vector_external_o, config_write_enable_o;
    logic time_protect_lift_o, prot_window_open_o, illegal_opcode_test_o, internal_rom_map_o;
    logic eeprom_map_o, watchdog_enable_o, timer_chain_bypass_o, system_reset_req_o;
    logic forced_cm_reset_o, forced_wd_reset_o, baud_chain_clear_o, port_d_line_one_o;
    logic instruction_start_pin_o, test_addr_drive_o;
    logic [15:0] test_addr_o;
    int n_errors = 0, n_compared = 0, n_cm = 0, n_wd = 0, n_bc = 0;

    // =====================================================================
    // Clock, device and pulse counters
    always #2 clk_i = ~clk_i;
    smtc_top #(.PROT_CYCLES(64)) smtc_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .mode_select_b_pin_i,
        .mode_select_a_pin_i, .rom_enable_config_i, .eeprom_enable_config_i,
        .watchdog_disable_config_i, .clock_monitor_enable_i, .watchdog_timeout_i,
        .clock_monitor_fail_i, .ccr_flags_i, .port_a_normal_i, .illegal_opcode_seen_i,
        .rx_clock_16x_i, .tx_clock_i, .port_d_line_one_normal_i, .addr_bus_i,
        .special_mode_flag_o, .boot_rom_enable_o(), .expansion_bus_mode_bit_o(),
        .internal_read_visibility_o(), .vector_base_o, .boot_rom_map_o, .reset_vector_external_o,
        .config_write_enable_o, .time_protect_lift_o, .prot_window_open_o, .illegal_opcode_test_o,
        .instruction_start_pin_o, .test_addr_o, .test_addr_drive_o, .port_a_o,
        .internal_rom_map_o, .eeprom_map_o, .watchdog_enable_o, .timer_chain_bypass_o,
        .system_reset_req_o, .forced_cm_reset_o, .forced_wd_reset_o, .baud_chain_clear_o,
        .port_d_line_one_o);
    // Pulses are counted, so their exact cycle does not matter to the bench
    always @(posedge clk_i)
    begin
        n_cm <= n_cm + int'(forced_cm_reset_o === 1'b1);
        n_wd <= n_wd + int'(forced_wd_reset_o === 1'b1);
        n_bc <= n_bc + int'(baud_chain_clear_o === 1'b1);
    end

    // =====================================================================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: held until ack or err is sampled, then released
    task bus(input logic we, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_sel_i, wb_we_i, wb_adr_i, wb_dat_i} <= {3'h7, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_sel_i, wb_we_i} <= 4'h0;
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    // Write, then compare pulse counts with the expected deltas
    task wrp(input logic [15:0] a, input logic [7:0] d, input int c, input int w, input int b);
        int c0, w0, b0;
        {c0, w0, b0} = {n_cm, n_wd, n_bc};
        bus(1'b1, a, d);
        repeat (3) @(posedge clk_i);
        chk(16'(n_cm - c0), 16'(c));
        chk(16'(n_wd - w0), 16'(w));
        chk(16'(n_bc - b0), 16'(b));
    endtask
    task do_reset(input logic b, input logic a);
        @(posedge clk_i);
        {rst_i, mode_select_b_pin_i, mode_select_a_pin_i} <= {1'b1, b, a};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task final_report;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        do_reset(1'b0, 1'b0);
        chk(special_mode_flag_o, 1'h1);
        chk(vector_base_o, 16'hbfc0);
        chk(boot_rom_map_o, 1'h1);
        chk(config_write_enable_o, 1'h1);
        chk(time_protect_lift_o, 1'h1);
        rdc(16'h103e, 8'h08);
        watchdog_timeout_i <= 1'b1;
        wrp(16'h103e, 8'hff, 0, 0, 0);
        rdc(16'h103e, 8'hb9);
        chk(system_reset_req_o, 1'h0);
        chk(timer_chain_bypass_o, 1'h1);
        chk(illegal_opcode_test_o, 1'h1);
        chk(internal_rom_map_o, 1'h0);
        chk(port_a_o, 16'h00ad);
        // Illegal opcode seen: start pin flags it, then the address counts down
        {addr_bus_i, illegal_opcode_seen_i} <= {16'h1234, 1'b1};
        @(posedge clk_i);
        chk(instruction_start_pin_o, 1'h1);
        illegal_opcode_seen_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({test_addr_drive_o, test_addr_o}, 32'h11232);
        wrp(16'h103e, 8'h00, 0, 0, 0);
        chk(system_reset_req_o, 1'h1);
        chk(port_a_o, 16'h00a5);
        watchdog_timeout_i <= 1'b0;
        wrp(16'h103e, 8'h04, 1, 0, 0);
        wrp(16'h103e, 8'h02, 0, 1, 0);
        {clock_monitor_enable_i, watchdog_disable_config_i} <= 2'h1;
        {rom_enable_config_i, eeprom_enable_config_i} <= 2'h0;
        wrp(16'h103e, 8'h06, 0, 0, 0);
        // Override must already stand when the forced timeout is written
        wrp(16'h103e, 8'h01, 0, 0, 0);
        wrp(16'h103e, 8'h03, 0, 1, 0);
        chk({watchdog_enable_o, internal_rom_map_o, eeprom_map_o}, 16'h0007);
        wrp(16'h103e, 8'h00, 0, 0, 0);
        chk({watchdog_enable_o, eeprom_map_o}, 16'h0000);
        rx_clock_16x_i <= 1'b1;
        wrp(16'h102b, 8'hc0, 0, 0, 1);
        rdc(16'h102b, 8'h00);
        chk(port_d_line_one_o, 1'h1);
        bus(1'b0, 16'h1000, 8'h00);
        chk(er, 1'h1);
        wrp(16'h103c, 8'h60, 0, 0, 0);
        rdc(16'h103c, 8'h60);
        wrp(16'h103c, 8'h50, 0, 0, 0);
        rdc(16'h103c, 8'h40);
        wrp(16'h103c, 8'h00, 0, 0, 0);
        chk({special_mode_flag_o, vector_base_o}, 16'hffc0);
        chk(port_d_line_one_o, 1'h0);
        wrp(16'h103e, 8'hff, 0, 0, 0);
        rdc(16'h103e, 8'h00);
        wrp(16'h103c, 8'h40, 0, 0, 0);
        chk(special_mode_flag_o, 1'h0);
        do_reset(1'b0, 1'b1);
        chk(reset_vector_external_o, 1'h1);
        do_reset(1'b1, 1'b0);
        chk({special_mode_flag_o, time_protect_lift_o, config_write_enable_o}, 16'h0);
        chk(prot_window_open_o, 1'h1);
        rdc(16'h103e, 8'h00);
        // Well past the protection window it must have closed
        repeat (70) @(posedge clk_i);
        chk(prot_window_open_o, 1'h0);
        final_report;
    end
    // Watchdog: the sequence needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        final_report;
    end
endmodule // smtc_top_tb
